// *** logic/ums_modem_status.sv ***
// modem status, scratchpad and configuration registers of one serial port
`timescale 1ns/100ps
`default_nettype none
module ums_modem_status
  import ums_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // embedded controller register port
  input wire logic [11:0] ec_addr_i,
  input wire logic ec_wr_i,
  input wire logic ec_rd_i,
  input wire logic [7:0] ec_wdata_i,
  output logic [7:0] ec_rdata_o,
  // host configuration port, index already qualified by device number
  input wire logic [7:0] host_index_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  // modem control register from the line control logic
  input wire logic [7:0] modem_control_reg_i,
  // active low modem pins
  input wire logic carrier_detect_n_i,
  input wire logic ring_n_i,
  input wire logic set_ready_n_i,
  input wire logic clear_send_n_i,
  // serial data path pins
  input wire logic core_tx_i,
  input wire logic pin_rx_i,
  output logic pin_tx_o,
  output logic core_rx_o,
  // reset sources and clock selection
  input wire logic system_domain_reset_i,
  input wire logic host_domain_reset_i,
  output logic port_reset_o,
  output logic port_active_o,
  output logic baud_clock_select_o,
  output logic modem_irq_o
);
  import ums_pkg::*;

  logic [7:0] byte_a_byte;
  logic activate;
  logic [2:0] config_sel;
  logic [3:0] pins_q;
  logic [3:0] flags;
  logic [7:0] next_byte_a_byte;
  logic next_activate;
  logic [2:0] next_config_sel;
  logic [3:0] next_pins_q;
  logic [3:0] next_flags;
  logic [3:0] pins_now;
  logic [3:0] status_hi;
  logic [7:0] modem_line_state;
  logic status_read;
  logic [7:0] ec_rdata_nx;
  logic [7:0] host_rdata_nx;

  // pins as inverted levels: carrier, ring, set-ready, clear-to-send
  assign pins_now = {~carrier_detect_n_i, ~ring_n_i, ~set_ready_n_i,
                     ~clear_send_n_i};

  // upper status nibble from pins or looped-back controls
  always_comb
  begin
    if (modem_control_reg_i[MCR_LOOPBACK])
      status_hi = {modem_control_reg_i[MCR_AUX_TWO],
                   modem_control_reg_i[MCR_AUX_ONE],
                   modem_control_reg_i[MCR_TERM_READY],
                   modem_control_reg_i[MCR_REQ_SEND]};
    else
      status_hi = pins_now;
  end

  assign modem_line_state = {status_hi, flags};
  assign status_read = ec_rd_i && (ec_addr_i == OFF_MODEM_LINE_STATE);

  // next register values, change detection and read clear
  always_comb
  begin
    next_byte_a_byte = byte_a_byte;
    next_activate = activate;
    next_config_sel = config_sel;
    next_pins_q = pins_now;
    next_flags = status_read ? RST_FLAGS : flags;
    // set wins over read clear
    if (pins_now[0] != pins_q[0])
      next_flags[0] = 1'b1;
    if (pins_now[1] != pins_q[1])
      next_flags[1] = 1'b1;
    // trailing ring edge: inverted level falls as the pin goes high
    if (!pins_now[2] && pins_q[2])
      next_flags[2] = 1'b1;
    if (pins_now[3] != pins_q[3])
      next_flags[3] = 1'b1;
    if (ec_wr_i && ec_addr_i == OFF_BYTE_A_BYTE)
      next_byte_a_byte = ec_wdata_i;
    // controller writes take priority over host writes in one cycle
    if (host_wr_i && host_index_i == IDX_ACTIVATE)
      next_activate = host_wdata_i[ACT_ENABLE];
    if (host_wr_i && host_index_i == IDX_CONFIG)
      next_config_sel = host_wdata_i[2:0];
    if (ec_wr_i && ec_addr_i == OFF_EC_ACTIVATE)
      next_activate = ec_wdata_i[ACT_ENABLE];
    if (ec_wr_i && ec_addr_i == OFF_EC_CONFIG)
      next_config_sel = ec_wdata_i[2:0];
  end

  // read data, unmapped offsets read zero
  always_comb
  begin
    unique case (ec_addr_i)
      OFF_MODEM_LINE_STATE: ec_rdata_nx = modem_line_state;
      OFF_BYTE_A_BYTE: ec_rdata_nx = byte_a_byte;
      OFF_EC_ACTIVATE: ec_rdata_nx = {7'h00, activate};
      OFF_EC_CONFIG: ec_rdata_nx = {5'h00, config_sel};
      default: ec_rdata_nx = 8'h00;
    endcase
    unique case (host_index_i)
      IDX_ACTIVATE: host_rdata_nx = {7'h00, activate};
      IDX_CONFIG: host_rdata_nx = {5'h00, config_sel};
      default: host_rdata_nx = 8'h00;
    endcase
  end

  // register stage; pin history is taken at reset so no false change flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      byte_a_byte <= RST_BYTE_A;
      activate <= RST_ACTIVATE[ACT_ENABLE];
      config_sel <= RST_CONFIG;
      pins_q <= pins_now;
      flags <= RST_FLAGS;
      ec_rdata_o <= 8'h00;
      host_rdata_o <= 8'h00;
    end
    else
    begin
      byte_a_byte <= next_byte_a_byte;
      activate <= next_activate;
      config_sel <= next_config_sel;
      pins_q <= next_pins_q;
      flags <= next_flags;
      ec_rdata_o <= ec_rd_i ? ec_rdata_nx : ec_rdata_o;
      host_rdata_o <= host_rd_i ? host_rdata_nx : host_rdata_o;
    end
  end

  // outputs driven by the change flags and by configuration
  assign modem_irq_o = |flags;
  assign port_active_o = activate;
  assign baud_clock_select_o = config_sel[CFG_BAUD_CLOCK];
  assign port_reset_o = config_sel[CFG_RESET_SRC] ? host_domain_reset_i
                        : system_domain_reset_i;
  assign pin_tx_o = core_tx_i ^ config_sel[CFG_POLARITY];
  assign core_rx_o = pin_rx_i ^ config_sel[CFG_POLARITY];

  // checks
  a_flag_read_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    status_read && (pins_now == pins_q) |=> flags == 4'h0)
    else $error("change flags not cleared by status read");
  a_cts_change_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pins_now[0] != pins_q[0] |=> flags[0])
    else $error("clear-to-send change not flagged");
  a_dsr_change_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pins_now[1] != pins_q[1] |=> flags[1])
    else $error("set-ready change not flagged");
  a_ring_fall_ignored: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pins_now[2] && !pins_q[2] && !flags[2] |=> !flags[2])
    else $error("ring leading edge set its flag");
  a_ring_trail_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !pins_now[2] && pins_q[2] |=> flags[2])
    else $error("ring trailing edge not flagged");
  a_carrier_change_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pins_now[3] != pins_q[3] |=> flags[3])
    else $error("carrier change not flagged");
  a_irq_follows_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(flags[3]) |-> modem_irq_o)
    else $error("interrupt missing while flag set");
  a_loop_status_hi: assert property (
    @(posedge clk_i) disable iff (rst_i)
    modem_control_reg_i[MCR_LOOPBACK] |->
      modem_line_state[7] == modem_control_reg_i[MCR_AUX_TWO])
    else $error("loopback status bit 7 wrong");
  a_pin_status_hi: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !modem_control_reg_i[MCR_LOOPBACK] |->
      modem_line_state[4] == !clear_send_n_i)
    else $error("status bit 4 not inverse of pin");
  a_byte_a_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ec_wr_i && ec_addr_i == OFF_BYTE_A_BYTE |=>
      byte_a_byte == $past(ec_wdata_i))
    else $error("byte_a byte not stored");
  a_polarity_tx: assert property (
    @(posedge clk_i) disable iff (rst_i)
    config_sel[CFG_POLARITY] |-> pin_tx_o == !core_tx_i)
    else $error("transmit pin not inverted");
  a_cfg_write_ec: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ec_wr_i && ec_addr_i == OFF_EC_ACTIVATE |=>
      port_active_o == $past(ec_wdata_i[0]))
    else $error("activate write lost");
  // host write lands when the controller is not writing in the same cycle
  a_host_cfg_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    host_wr_i && !ec_wr_i && host_index_i == IDX_CONFIG |=>
      config_sel == $past(host_wdata_i[2:0]))
    else $error("host config write lost");
endmodule
`default_nettype wire

// *** logic/ums_pkg.sv ***
// constants for the serial port modem status and configuration block
package ums_pkg;
  // runtime register offsets
  localparam logic [11:0] OFF_MODEM_LINE_STATE = 12'h006;
  localparam logic [11:0] OFF_BYTE_A_BYTE = 12'h007;
  // embedded controller offsets of the configuration registers
  localparam logic [11:0] OFF_EC_ACTIVATE = 12'h330;
  localparam logic [11:0] OFF_EC_CONFIG = 12'h3f0;
  // host configuration port indexes
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_CONFIG = 8'hf0;
  // modem control field positions
  localparam int MCR_TERM_READY = 0;
  localparam int MCR_REQ_SEND = 1;
  localparam int MCR_AUX_ONE = 2;
  localparam int MCR_AUX_TWO = 3;
  localparam int MCR_LOOPBACK = 4;
  // configuration select and activate field positions
  localparam int CFG_BAUD_CLOCK = 0;
  localparam int CFG_RESET_SRC = 1;
  localparam int CFG_POLARITY = 2;
  localparam int ACT_ENABLE = 0;
  // reset values
  localparam logic [7:0] RST_BYTE_A = 8'h00;
  localparam logic [7:0] RST_ACTIVATE = 8'h00;
  localparam logic [2:0] RST_CONFIG = 3'h2;
  localparam logic [3:0] RST_FLAGS = 4'h0;
endpackage

// *** tb/ums_modem_peer.sv ***
// modem peer model that drives the active low modem pins
`timescale 1ns/100ps
`default_nettype none
module ums_modem_peer
(
  input wire logic clk_i,
  input wire logic [3:0] lines_i,
  output logic carrier_detect_n_o,
  output logic ring_n_o,
  output logic set_ready_n_o,
  output logic clear_send_n_o
);
  // pins change just after an edge, asserted level is low
  always_ff @(posedge clk_i)
  begin
    {carrier_detect_n_o, ring_n_o, set_ready_n_o, clear_send_n_o} <= ~lines_i;
  end
endmodule
`default_nettype wire

// *** tb/ums_modem_status_tb.sv ***
// self-checking bench for the modem status and configuration block
`timescale 1ns/100ps
`default_nettype none
module ums_modem_status_tb;
  import ums_pkg::*;
  logic clk_i = 0, rst_i = 1, ec_wr, ec_rd, h_wr, h_rd, tx = 1, rx = 0;
  logic sysr = 1, hstr = 0, cd_n, ri_n, dsr_n, cts_n;
  logic [11:0] ec_a = 12'h000;
  logic [7:0] h_a = 8'h00, wd = 8'h00, modem_control_reg = 8'h00, ec_q, h_q, got;
  logic [3:0] lines = 4'h0;
  logic p_tx, c_rx, p_rst, act, baud, irq;
  int failures = 0, comparisons = 0;
  initial {ec_wr, ec_rd, h_wr, h_rd} = 4'h0;
  initial forever #4 clk_i = ~clk_i;
  ums_modem_peer peer_u (.clk_i(clk_i), .lines_i(lines),
    .carrier_detect_n_o(cd_n), .ring_n_o(ri_n), .set_ready_n_o(dsr_n),
    .clear_send_n_o(cts_n));
  ums_modem_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .ec_addr_i(ec_a),
    .ec_wr_i(ec_wr), .ec_rd_i(ec_rd), .ec_wdata_i(wd), .ec_rdata_o(ec_q),
    .host_index_i(h_a), .host_wr_i(h_wr), .host_rd_i(h_rd),
    .host_wdata_i(wd), .host_rdata_o(h_q), .modem_control_reg_i(modem_control_reg),
    .carrier_detect_n_i(cd_n), .ring_n_i(ri_n), .set_ready_n_i(dsr_n),
    .clear_send_n_i(cts_n), .core_tx_i(tx), .pin_rx_i(rx),
    .pin_tx_o(p_tx), .core_rx_o(c_rx), .system_domain_reset_i(sysr),
    .host_domain_reset_i(hstr), .port_reset_o(p_rst),
    .port_active_o(act), .baud_clock_select_o(baud), .modem_irq_o(irq));
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one access on the controller port or the host port, read data in got
  task automatic bus(input logic h, input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk_i);
    ec_a <= a;
    h_a <= a[7:0];
    wd <= d;
    {h_wr, h_rd, ec_wr, ec_rd} <= h ? {w, !w, 2'b00} : {2'b00, w, !w};
    @(posedge clk_i);
    {h_wr, h_rd, ec_wr, ec_rd} <= 4'h0;
    @(posedge clk_i);
    #1 got = h ? h_q : ec_q;
  endtask
  task automatic pins(input logic [3:0] l, input logic [7:0] e);
    @(posedge clk_i);
    lines <= l;
    repeat (4) @(posedge clk_i);
    #1 check({7'h00, irq}, {7'h00, |e[3:0]});
    bus(0, 0, OFF_MODEM_LINE_STATE, 8'h00);
    check(got, e);
    bus(0, 0, OFF_MODEM_LINE_STATE, 8'h00);
    check(got, {e[7:4], 4'h0});
    check({7'h00, irq}, 8'h00);
  endtask
  task automatic t_reset;
    bus(0, 0, OFF_BYTE_A_BYTE, 8'h00);
    check(got, RST_BYTE_A);
    bus(0, 0, OFF_EC_ACTIVATE, 8'h00);
    check(got, RST_ACTIVATE);
    bus(1, 0, {4'h0, IDX_CONFIG}, 8'h00);
    check(got, {5'h00, RST_CONFIG});
    check({4'h0, p_rst, baud, p_tx, c_rx}, 8'h02);
    bus(0, 0, 12'h123, 8'h00);
    check(got, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_status;
    pins(4'b1011, 8'hbb);
    pins(4'b1111, 8'hf0);
    pins(4'b1011, 8'hb4);
    pins(4'b0011, 8'h38);
    modem_control_reg <= 8'h15;
    bus(0, 0, OFF_MODEM_LINE_STATE, 8'h00);
    check(got & 8'hf0, 8'h60);
    modem_control_reg <= 8'h1a;
    bus(0, 0, OFF_MODEM_LINE_STATE, 8'h00);
    check(got & 8'hf0, 8'h90);
    modem_control_reg <= 8'h00;
    $display("status test done");
  endtask
  task automatic t_config;
    bus(0, 1, OFF_BYTE_A_BYTE, 8'ha5);
    bus(0, 0, OFF_BYTE_A_BYTE, 8'h00);
    check(got, 8'ha5);
    bus(0, 1, OFF_EC_ACTIVATE, 8'hff);
    bus(1, 0, {4'h0, IDX_ACTIVATE}, 8'h00);
    check(got, 8'h01);
    check({7'h00, act}, 8'h01);
    bus(0, 1, OFF_EC_CONFIG, 8'hf9);
    check({5'h00, p_rst, baud, p_tx}, 8'h07);
    bus(0, 0, OFF_EC_CONFIG, 8'h00);
    check(got, 8'h01);
    bus(1, 1, {4'h0, IDX_CONFIG}, 8'hff);
    bus(0, 0, OFF_EC_CONFIG, 8'h00);
    check(got, 8'h07);
    check({5'h00, p_rst, p_tx, c_rx}, 8'h01);
    $display("config test done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_status();
    t_config();
    end_of_test();
  end
  // watchdog against a hung run
  initial
  begin
    #20000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
